//--- hw/ee_slave.sv
// ee_slave: two-wire serial eeprom slave, protocol engine and top level
// Behaviour
// - page write takes sixteen bytes, one cycle
// - ack each data byte, bump page offset
// - offset wraps inside page, overwriting buffered bytes
// - program cycle starts at stop only
// - no address ack while programming
// - protect pin high makes array read-only
// - protect pin high blocks lock programming
// - pin low: writable except locked lower half
// - lock bit one-time, survives every reset
// - lock written via byte write, code 0110
// - lock address refused after first programming
// - counter holds last address plus one, wrapping inside the page after a write
// - immediate read sends byte at counter
// - next byte per master ack, stop on nack
// - sequential read walks whole array, wraps
// - answer only 1010 or 0110 plus matching straps
// - address bit zero selects read or write
// - write mode acks every byte
module ee_slave #(
    parameter int WR_CYCLES = ee_pkg::EE_WR_CYCLES // program cycle length
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic strap_bit0,
    input wire logic strap_bit1,
    input wire logic strap_bit2,
    input wire logic wp,
    output logic prog_busy,
    output logic soft_lock
);
    import ee_pkg::*;

    ee_arr_if a ();

    // pin synchronisers: {wp, straps, sda, scl}
    logic [5:0] pin_m_q; // first stage, read only by second
    logic [5:0] pin_s_q; // second stage, safe to use
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] straps;
    // previous samples for edge and condition detection
    logic scl_p_q;
    logic sda_p_q;
    logic start_ev; // sda falls while scl high
    logic stop_ev; // sda rises while scl high
    logic rise;
    logic fall;
    // link byte from the scl domain
    logic [7:0] link_byte;
    // engine state
    ee_state_t st_q;
    logic [3:0] cnt_q; // scl rises seen in this byte
    logic active; // inside a frame that concerns us
    logic fall_ack; // fall after eighth rise: byte complete
    logic fall_end; // fall after ninth rise: ack slot over
    ee_kind_t kind;
    logic dev_ok; // address byte accepted
    logic ack_q; // pulling sda for an ack
    logic is_lock_q; // this frame targets the lock bit
    logic got_q; // page data waiting for stop
    logic lockp_q; // lock data byte received
    logic mack_q; // master wants another byte
    logic [7:0] addr_q; // address counter
    logic [7:0] tx_q; // outgoing byte, msb on the wire
    logic txon_q; // driving data bits
    logic oe_q;
    // registered requests to the array side
    logic wr_q;
    logic [3:0] widx_q;
    logic [7:0] wdat_q;
    logic [3:0] wpage_q;
    logic clr_q;
    logic commit_q;
    logic lreq_q;

    // two flops on every pin before core-clock logic looks at it; ee_samp takes scl and sda raw
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_m_q <= EE_PIN_IDLE;
            pin_s_q <= EE_PIN_IDLE;
        end else begin
            pin_m_q <= {wp, strap_bit2, strap_bit1, strap_bit0, sda_i, scl};
            pin_s_q <= pin_m_q;
        end
    end

    assign scl_s = pin_s_q[0];
    assign sda_s = pin_s_q[1];
    assign straps = pin_s_q[4:2];
    assign wp_s = pin_s_q[5];

    // last synchronised levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // both pins pass equal delay, so their order is kept
    assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign rise = scl_s && !scl_p_q;
    assign fall = !scl_s && scl_p_q;

    // bits are caught on the real scl edge, not on the slow copy
    ee_samp u_samp (
        .scl(scl),
        .rst_n(rst_n),
        .sda_i(sda_i),
        .shift_q(link_byte)
    );

    assign active = st_q != ST_IDLE && st_q != ST_WAIT;
    assign fall_ack = active && fall && cnt_q == EE_BIT_ACK;
    assign fall_end = active && fall && cnt_q == EE_BIT_END;

    // address decode; busy or used lock bit means no answer
    always_comb begin
        kind = ee_kind(link_byte, straps);
        dev_ok = 1'b0;
        if (kind == KIND_ARRAY && !a.busy) begin
            dev_ok = 1'b1;
        end else if (kind == KIND_LOCK && !a.busy && !a.lock && !link_byte[0]) begin
            dev_ok = 1'b1;
        end
    end

    // rise counter within one byte plus ack slot
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (start_ev || fall_end) begin
            cnt_q <= 4'h0;
        end else if (active && rise && cnt_q != EE_BIT_END) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // frame state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else if (start_ev) begin
            st_q <= ST_DEV;
        end else if (stop_ev) begin
            st_q <= ST_IDLE;
        end else if (fall_ack) begin
            case (st_q)
                ST_DEV: begin
                    if (!dev_ok) begin
                        st_q <= ST_WAIT;
                    end else if (link_byte[0]) begin
                        st_q <= ST_RDATA;
                    end else begin
                        st_q <= ST_WORD;
                    end
                end
                ST_WORD: st_q <= ST_WDATA;
                default: st_q <= st_q;
            endcase
        end else if (fall_end && st_q == ST_RDATA && !mack_q) begin
            st_q <= ST_WAIT;
        end
    end

    // ack slot drive
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else if (start_ev || stop_ev || fall_end) begin
            ack_q <= 1'b0;
        end else if (fall_ack) begin
            case (st_q)
                ST_DEV: ack_q <= dev_ok;
                ST_WORD: ack_q <= 1'b1;
                ST_WDATA: ack_q <= 1'b1;
                default: ack_q <= 1'b0;
            endcase
        end
    end

    // frame target and pending write data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            is_lock_q <= 1'b0;
            got_q <= 1'b0;
            lockp_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            is_lock_q <= 1'b0;
            got_q <= 1'b0;
            lockp_q <= 1'b0;
        end else if (fall_ack && st_q == ST_DEV) begin
            is_lock_q <= kind == KIND_LOCK;
        end else if (fall_ack && st_q == ST_WDATA) begin
            got_q <= got_q || !is_lock_q;
            lockp_q <= lockp_q || is_lock_q;
        end
    end

    // address counter: page offset on write, full width on read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 8'h00;
        end else if (fall_ack && st_q == ST_WORD && !is_lock_q) begin
            addr_q <= link_byte;
        end else if (fall_ack && st_q == ST_WDATA && !is_lock_q) begin
            addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1};
        end else if (fall_ack && st_q == ST_RDATA) begin
            addr_q <= addr_q + 8'h01;
        end
    end

    // master ack sampled on the ninth rise; address ack counts as one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mack_q <= 1'b0;
        end else if (fall_ack && st_q == ST_DEV) begin
            mack_q <= 1'b1;
        end else if (rise && st_q == ST_RDATA && cnt_q == EE_BIT_ACK) begin
            mack_q <= !sda_s;
        end
    end

    // transmitter: load at end of ack slot, shift on each fall
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= 8'hff;
            txon_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            txon_q <= 1'b0;
        end else if (fall_end && st_q == ST_RDATA && mack_q) begin
            tx_q <= a.rd_data;
            txon_q <= 1'b1;
        end else if (fall_ack && st_q == ST_RDATA) begin
            txon_q <= 1'b0; // release for master ack
        end else if (fall && st_q == ST_RDATA && cnt_q != 4'h0) begin
            tx_q <= {tx_q[6:0], 1'b1};
        end
    end

    // buffer writes; counter already moved on the same edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            widx_q <= 4'h0;
            wdat_q <= 8'h00;
            wpage_q <= 4'h0;
        end else begin
            wr_q <= fall_ack && st_q == ST_WDATA && !is_lock_q;
            if (fall_ack && st_q == ST_WDATA) begin
                widx_q <= addr_q[3:0];
                wdat_q <= link_byte;
                wpage_q <= addr_q[7:4];
            end
        end
    end

    // commit only on stop after data; start drops stale data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_q <= 1'b0;
            commit_q <= 1'b0;
            lreq_q <= 1'b0;
        end else begin
            clr_q <= start_ev;
            commit_q <= stop_ev && (got_q || lockp_q) && !a.busy;
            lreq_q <= stop_ev && lockp_q;
        end
    end

    // open drain: only ever pull low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ack_q || (txon_q && !tx_q[7]);
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign prog_busy = a.busy;
    assign soft_lock = a.lock;

    assign a.rd_addr = addr_q;
    assign a.wr_en = wr_q;
    assign a.wr_idx = widx_q;
    assign a.wr_data = wdat_q;
    assign a.page = wpage_q;
    assign a.clr = clr_q;
    assign a.commit = commit_q;
    assign a.lock_req = lreq_q;
    assign a.wp = wp_s;

    ee_arr #(
        .WR_CYCLES(WR_CYCLES)
    ) u_arr (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .port(a.arr)
    );

    chk_busy_nack: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fall_ack && st_q == ST_DEV && a.busy) |=> !ack_q ##1 !sda_oe)
        else $error("address acked while busy");
    chk_addr_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fall_ack && st_q == ST_DEV && kind == KIND_ARRAY && !a.busy) |=> ack_q ##1 sda_oe)
        else $error("matching address not acked");
    chk_page_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_q |-> addr_q[7:4] == $past(addr_q[7:4]) && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1)
        else $error("page offset step wrong");
    chk_read_inc: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fall_ack && st_q == ST_RDATA) |=> addr_q == $past(addr_q) + 8'h01)
        else $error("read counter step wrong");
    chk_nack_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fall_end && st_q == ST_RDATA && !mack_q && !start_ev && !stop_ev)
        |=> st_q == ST_WAIT ##1 !sda_oe)
        else $error("still sending after nack");
    chk_commit_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
        commit_q |-> $past(stop_ev)) else $error("commit without stop");
    chk_lock_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fall_ack && st_q == ST_DEV && kind == KIND_LOCK && a.lock) |=> !ack_q && st_q == ST_WAIT)
        else $error("lock address acked twice");
endmodule

//--- hw/ee_pkg.sv
// ee_pkg: constants, types and decode helpers of the serial eeprom slave
package ee_pkg;
    // slave address codes in the upper nibble
    localparam logic [3:0] EE_ARRAY_CODE = 4'ha;
    localparam logic [3:0] EE_LOCK_CODE = 4'h6;
    // array geometry
    localparam int EE_DEPTH = 256;
    localparam int EE_PAGE_BYTES = 16;
    localparam logic [7:0] EE_LOCK_LIMIT = 8'h80;
    // bit counter values: 8 = ack slot, 9 = byte finished
    localparam logic [3:0] EE_BIT_ACK = 4'h8;
    localparam logic [3:0] EE_BIT_END = 4'h9;
    // idle bus level of scl and sda after reset
    localparam logic [5:0] EE_PIN_IDLE = 6'h03;
    // program cycle time, worst case, counted in core cycles
    localparam int EE_CLK_MHZ = 125;
    localparam int EE_T_WR_US = 10000;
    localparam int EE_WR_CYCLES = EE_T_WR_US * EE_CLK_MHZ;
    localparam int EE_CNT_W = 21;

    // protocol engine states
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WORD, ST_WDATA, ST_RDATA, ST_WAIT} ee_state_t;
    // what a slave address byte selects
    typedef enum logic [1:0] {KIND_NONE, KIND_ARRAY, KIND_LOCK} ee_kind_t;

    // classify a slave address byte against the straps
    function automatic ee_kind_t ee_kind(input logic [7:0] b, input logic [2:0] straps);
        ee_kind_t k;
        k = KIND_NONE;
        if (b[3:1] == straps && b[7:4] == EE_ARRAY_CODE) begin
            k = KIND_ARRAY;
        end else if (b[3:1] == straps && b[7:4] == EE_LOCK_CODE) begin
            k = KIND_LOCK;
        end
        return k;
    endfunction

    // true when a location may not be programmed
    function automatic logic ee_prot(input logic [7:0] addr, input logic wp, input logic lock);
        return wp || (lock && addr < EE_LOCK_LIMIT);
    endfunction
endpackage

//--- hw/ee_arr_if.sv
// ee_arr_if: link between protocol engine and array/program logic
interface ee_arr_if;
    logic [7:0] rd_addr; // address counter
    logic [7:0] rd_data; // byte at rd_addr, registered
    logic wr_en; // one byte into the page buffer
    logic [3:0] wr_idx; // slot within the page
    logic [7:0] wr_data;
    logic [3:0] page; // upper address bits of the page
    logic clr; // drop buffered bytes
    logic commit; // start program cycle
    logic lock_req; // program the lock bit in this cycle
    logic wp; // synchronised protect pin
    logic busy; // program cycle running
    logic lock; // lock bit state
    modport core (
        output rd_addr, wr_en, wr_idx, wr_data, page, clr, commit, lock_req, wp,
        input rd_data, busy, lock
    );
    modport arr (
        input rd_addr, wr_en, wr_idx, wr_data, page, clr, commit, lock_req, wp,
        output rd_data, busy, lock
    );
endinterface

//--- hw/ee_samp.sv
// ee_samp: link-clock side, samples sda on each rising scl edge
module ee_samp (
    input wire logic scl,
    input wire logic rst_n,
    input wire logic sda_i,
    output logic [7:0] shift_q
);
    import ee_pkg::*;

    // shifter only moves on scl rise, so it stays still through the
    // whole low phase; the core reads it only after a synchronised fall
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
        end else begin
            shift_q <= {shift_q[6:0], sda_i};
        end
    end
endmodule

//--- hw/ee_arr.sv
// ee_arr: 256 byte array, page buffer, program timer and lock bit
module ee_arr #(
    parameter int WR_CYCLES = ee_pkg::EE_WR_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    ee_arr_if.arr port
);
    import ee_pkg::*;

    logic [7:0] mem_q [EE_DEPTH]; // array, never reset
    logic [7:0] pbuf_q [EE_PAGE_BYTES]; // page buffer data
    logic [EE_PAGE_BYTES-1:0] pmask_q; // slots holding data
    logic [3:0] page_q; // page of the buffered bytes
    logic [EE_CNT_W-1:0] cnt_q; // program cycle countdown
    logic busy_q;
    logic pwp_q; // protect pin taken at commit
    logic plock_q; // lock bit taken at commit
    logic lockp_q; // lock programming pending
    logic [7:0] rd_q;
    logic lock_q = 1'b0; // power-on value only: no reset may clear it
    logic done;

    assign done = busy_q && cnt_q == EE_CNT_W'(1);
    assign port.busy = busy_q;
    assign port.lock = lock_q;
    assign port.rd_data = rd_q;

    // program cycle timer, started only by a commit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else if (port.commit && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= EE_CNT_W'(WR_CYCLES);
        end else if (done) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - EE_CNT_W'(1);
        end
    end

    // protection snapshot; protect pin blocks lock programming
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwp_q <= 1'b0;
            plock_q <= 1'b0;
            lockp_q <= 1'b0;
        end else if (port.commit && !busy_q) begin
            pwp_q <= port.wp;
            plock_q <= lock_q;
            lockp_q <= port.lock_req && !port.wp;
        end else if (done) begin
            lockp_q <= 1'b0;
        end
    end

    // slot flags; frozen while programming
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pmask_q <= '0;
            page_q <= 4'h0;
        end else if (done || (port.clr && !busy_q)) begin
            pmask_q <= '0;
        end else if (port.wr_en && !busy_q) begin
            pmask_q[port.wr_idx] <= 1'b1;
            page_q <= port.page;
        end
    end

    // buffer data; a repeated slot simply overwrites
    always_ff @(posedge core_clk) begin
        if (port.wr_en && !busy_q) begin
            pbuf_q[port.wr_idx] <= port.wr_data;
        end
    end

    // all buffered bytes land in one cycle, protected ones skipped
    always_ff @(posedge core_clk) begin
        if (done) begin
            for (int i = 0; i < EE_PAGE_BYTES; i++) begin
                if (pmask_q[i] && !ee_prot({page_q, 4'(i)}, pwp_q, plock_q)) begin
                    mem_q[{page_q, 4'(i)}] <= pbuf_q[i];
                end
            end
        end
    end

    // one-time lock bit
    always_ff @(posedge core_clk) begin
        if (done && lockp_q) begin
            lock_q <= 1'b1;
        end
    end

    // registered read port
    always_ff @(posedge core_clk) begin
        rd_q <= mem_q[port.rd_addr];
    end

    chk_lock_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        lock_q |=> lock_q) else $error("lock bit cleared");
    chk_wp_no_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
        (port.commit && !busy_q && port.wp) |=> !lockp_q) else $error("lock armed under wp");
    chk_buf_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
        (busy_q && !done) |=> pmask_q == $past(pmask_q)) else $error("buffer moved in cycle");
endmodule

//--- test/ee_mst_model.sv
// ee_mst_model: behavioural two-wire bus master with its own 6 ns tick
module ee_mst_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tick; // link time base, phase unrelated to core_clk

    // scl idles high and stands still between frames
    initial begin
        tick = 1'b0;
        scl = 1'b1;
        sda_pull = 1'b0;
        #1.7;
        forever #3 tick = ~tick;
    end

    // one scl phase: 12 ticks, above the 8 core cycle minimum
    task automatic ph();
        repeat (12) @(posedge tick);
    endtask

    // start or repeated start: sda falls while scl is high
    task automatic start();
        sda_pull = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b1;
        ph();
        scl = 1'b0;
        ph();
    endtask

    // stop: sda rises while scl is high
    task automatic stop();
        sda_pull = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b0;
        ph();
    endtask

    // one byte out, msb first, ack sampled on the ninth clock
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~b[i];
            ph();
            scl = 1'b1;
            ph();
            scl = 1'b0;
        end
        sda_pull = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        ack = ~sda;
        scl = 1'b0;
    endtask

    // one byte in; ack high makes the master pull the ninth bit low
    task automatic rbyte(input logic ack, output logic [7:0] b);
        sda_pull = 1'b0;
        for (int i = 0; i < 8; i++) begin
            ph();
            scl = 1'b1;
            ph();
            b = {b[6:0], sda};
            scl = 1'b0;
        end
        sda_pull = ack;
        ph();
        scl = 1'b1;
        ph();
        scl = 1'b0;
    endtask
endmodule

//--- test/serial_eeprom_page_write_protect_read_bench.sv
// serial_eeprom_page_write_protect_read_bench: self-checking bench of the eeprom slave
module serial_eeprom_page_write_protect_read_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ee_pkg::*;
    localparam int WRC = 400; // short program cycle, longer than one poll frame
    logic core_clk, rst_n, wp, sda_o, sda_oe, prog_busy, soft_lock, scl, sda_pull, sda;
    logic [2:0] strap; // device address straps
    logic [7:0] exp_mem [256]; // expected array contents
    logic [7:0] ctr; // expected address counter
    logic lk; // expected lock state
    int mismatches, n_compared;

    // open-drain wire with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

    ee_slave #(.WR_CYCLES(WRC)) i_ee_slave (.core_clk(core_clk), .rst_n(rst_n), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .strap_bit0(strap[0]),
        .strap_bit1(strap[1]), .strap_bit2(strap[2]), .wp(wp), .prog_busy(prog_busy),
        .soft_lock(soft_lock));
    ee_mst_model i_ee_mst_model (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    // core clock, 8 ns
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one address frame, ack returned
    task automatic addr(input logic [7:0] b, output logic k);
        i_ee_mst_model.start();
        i_ee_mst_model.wbyte(b, k);
    endtask

    // poll with write address until acked, bounded
    task automatic wait_ready();
        logic k;
        for (int i = 0; i < 20; i++) begin
            addr({EE_ARRAY_CODE, strap, 1'b0}, k);
            i_ee_mst_model.stop();
            if (k === 1'b1) return;
        end
        chk("poll_ack", 8'h1, 8'h0);
        give_verdict();
    endtask

    // write frame of n bytes, then busy nack and polling
    task automatic wr(input logic [3:0] code, input logic [7:0] a, input int n,
        input logic [7:0] d0);
        logic k;
        logic [7:0] ad;
        addr({code, strap, 1'b0}, k);
        chk("addr_ack", 8'h1, 8'(k));
        i_ee_mst_model.wbyte(a, k);
        chk("word_ack", 8'h1, 8'(k));
        for (int i = 0; i < n; i++) begin
            ad = {a[7:4], a[3:0] + i[3:0]};
            i_ee_mst_model.wbyte(d0 + i[7:0], k);
            chk("data_ack", 8'h1, 8'(k));
            if (code == EE_ARRAY_CODE && !wp && !(lk && ad < 8'h80)) begin
                exp_mem[ad] = d0 + i[7:0];
            end
        end
        chk("busy_early", 8'h0, 8'(prog_busy));
        i_ee_mst_model.stop();
        chk("busy_set", 8'h1, 8'(prog_busy));
        lk = lk | (code == EE_LOCK_CODE && !wp);
        addr({EE_ARRAY_CODE, strap, 1'b0}, k);
        i_ee_mst_model.stop();
        chk("busy_nack", 8'h0, 8'(k));
        wait_ready();
    endtask

    // random or immediate read of n bytes, master acks all but the last
    task automatic rd(input logic rnd, input logic [7:0] a, input int n);
        logic k;
        logic [7:0] b;
        if (rnd) begin
            addr({EE_ARRAY_CODE, strap, 1'b0}, k);
            i_ee_mst_model.wbyte(a, k);
            ctr = a;
        end
        addr({EE_ARRAY_CODE, strap, 1'b1}, k);
        chk("read_ack", 8'h1, 8'(k));
        for (int i = 0; i < n; i++) begin
            i_ee_mst_model.rbyte(i != n - 1, b);
            chk("read_data", exp_mem[ctr + i[7:0]], b);
        end
        repeat (6) @(negedge core_clk);
        chk("read_release", 8'h0, 8'(sda_oe));
        i_ee_mst_model.stop();
        ctr = ctr + n[7:0];
    endtask

    // foreign straps and foreign code stay unanswered
    task automatic t_addr();
        logic k;
        addr({EE_ARRAY_CODE, strap ^ 3'h1, 1'b0}, k);
        i_ee_mst_model.stop();
        chk("strap_nack", 8'h0, 8'(k));
        addr({4'h2, strap, 1'b0}, k);
        i_ee_mst_model.stop();
        chk("code_nack", 8'h0, 8'(k));
        addr({EE_LOCK_CODE, strap, 1'b1}, k);
        i_ee_mst_model.stop();
        chk("lock_rd_nack", 8'h0, 8'(k));
    endtask

    // 18 bytes into one page: offset wraps, one program cycle
    task automatic t_page();
        wr(EE_ARRAY_CODE, 8'h3e, 18, 8'h40);
        rd(1'b1, 8'h30, 16);
    endtask

    // counter wraps 255 to 0, immediate read continues
    task automatic t_wrap();
        wr(EE_ARRAY_CODE, 8'h00, 3, 8'h10);
        wr(EE_ARRAY_CODE, 8'hff, 1, 8'hc3);
        rd(1'b1, 8'hff, 2);
        rd(1'b0, 8'h00, 1);
    endtask

    // protect pin high: array and lock untouched
    task automatic t_hwprot();
        @(negedge core_clk);
        wp = 1'b1;
        wr(EE_ARRAY_CODE, 8'h31, 1, 8'h99);
        wr(EE_LOCK_CODE, 8'h00, 1, 8'h00);
        chk("lock_wp", 8'h0, 8'(soft_lock));
        @(negedge core_clk);
        wp = 1'b0;
        rd(1'b1, 8'h31, 1);
    endtask

    // lock once, lower half frozen, survives reset
    task automatic t_lock();
        logic k;
        wr(EE_LOCK_CODE, 8'h00, 1, 8'h00);
        chk("lock_set", 8'h1, 8'(soft_lock));
        addr({EE_LOCK_CODE, strap, 1'b0}, k);
        i_ee_mst_model.stop();
        chk("lock_nack", 8'h0, 8'(k));
        wr(EE_ARRAY_CODE, 8'h01, 1, 8'h77);
        wr(EE_ARRAY_CODE, 8'h90, 1, 8'h85);
        rd(1'b1, 8'h00, 2);
        rd(1'b1, 8'h90, 1);
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("lock_reset", 8'h1, 8'(soft_lock));
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        strap = 3'h5;
        lk = 1'b0;
        ctr = 8'h00;
        mismatches = 0;
        n_compared = 0;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_addr();
        t_page();
        t_wrap();
        t_hwprot();
        t_lock();
        give_verdict();
    end
endmodule
